// file: lfs_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Enable low beyond about 16 ms puts the device to sleep.
// - First enable rise after sleep clears every latched fault.
// - After sleep, a full soft start runs when dimming next rises.
// - Enable high with dimming low over 16 ms clears latched faults, no sleep.
// - After that clear, the next dimming rise runs soft start again.
// - Bias supply and sync clock stay on whenever enable is high.
// - Fault line is open drain, pulled low for a reportable fault.
// - All-off variant: fault held low by others over 8 switching cycles stops all sinks and the boost; bias and sync clock stay on.
// - Any sink pin above short threshold is removed from regulation.
// - Standard variant: shorted channel alone disabled, fault latched until clear.
// - All-off variant: any partial short kills all sinks and latches fault.
// - Short detection armed only while some sink pin sits in regulation.
// - Overvoltage alone stops switching, is not latched and raises no fault.
// - Standard variant: startup overvoltage drops unregulated channels, raises fault.
// - Switching resumes for the remaining channels on the release flag.
// - All-off variant: startup overvoltage with unregulated string latches all off.
module lfs_supervisor import lfs_pkg::*; #(
	parameter int ENABLE_OFF_LIMIT = ENABLE_OFF_CYCLES,
	parameter int DIM_CLEAR_LIMIT = DIM_CLEAR_CYCLES,
	parameter int EXT_FAULT_LIMIT = EXT_FAULT_SW_CYCLES,
	parameter bit ALL_OFF_VARIANT = 1'b0
) (
	// Clock and reset.
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// Host control pins.
	input wire logic ENABLE_I,
	input wire logic DIM_I,
	// Comparator flags and switching-cycle tick.
	input wire logic [NUM_CH-1:0] SINK_ABOVE_SHORT_I,
	input wire logic [NUM_CH-1:0] SINK_IN_REG_I,
	input wire logic OVP_TRIP_I,
	input wire logic OVP_RELEASE_I,
	input wire logic SOFT_START_DONE_I,
	input wire logic SW_CYCLE_I,
	// Open-drain fault line.
	input wire logic FAULT_N_I,
	output logic FAULT_N_O,
	output logic FAULT_N_OE_O,
	// Power stage controls.
	output logic [NUM_CH-1:0] SINK_EN_O,
	output logic BOOST_EN_O,
	output logic BIAS_EN_O,
	output logic SYNC_CLK_EN_O,
	output logic SOFT_START_O,
	output logic SLEEP_O,
	output logic [NUM_CH-1:0] CH_LATCHED_OFF_O,
	output logic GLOBAL_LATCHED_OFF_O
);

	// The external-fault counter is eight bits wide and saturates at the limit.
	if (EXT_FAULT_LIMIT < 1 || EXT_FAULT_LIMIT > 255) begin : g_bad_ext_limit
		$error("lfs_supervisor: bad EXT_FAULT_LIMIT");
	end

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [2:0] en_sync;
		logic [2:0] dim_sync;
		logic [2:0] flt_sync;
		logic en_q;
		logic dim_q;
		logic flt_q;
		logic dim_prev;
		logic en_prev;
		lfs_phase_e phase;
		logic [NUM_CH-1:0] ch_off;
		logic global_off;
		logic fault_latch;
		logic ovp_hold;
		logic [7:0] ext_cnt;
		lfs_ctrl_s ctrl;
		logic fault_drive;
	} lfs_state_s;

	lfs_state_s r;
	lfs_state_s next_r;
	logic en_low_long;
	logic dim_low_long;

	////////////////////////////////////////////////////////////////////////////
	// Low-interval timers, fed by the filtered pin levels.

	lfs_low_timer #(
		.LIMIT(ENABLE_OFF_LIMIT),
		.W(TMR_W)
	) u_en_timer (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.level_i(r.en_q),
		.expired_o(en_low_long)
	);

	lfs_low_timer #(
		.LIMIT(DIM_CLEAR_LIMIT),
		.W(TMR_W)
	) u_dim_timer (
		.clk_i(CLK_I),
		.arst_n_i(ARST_N_I),
		.level_i(r.dim_q),
		.expired_o(dim_low_long)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Pins pass three flops; the filtered level moves only when stages two and three agree.
	always_comb begin
		logic clear_all;
		logic armed;
		logic [NUM_CH-1:0] short_hit;
		logic ovp_startup;
		logic ext_fault;
		next_r = r;
		clear_all = 1'b0;
		armed = 1'b0;
		short_hit = '0;
		ovp_startup = 1'b0;
		ext_fault = 1'b0;

		next_r.en_sync = {r.en_sync[1:0], ENABLE_I};
		next_r.dim_sync = {r.dim_sync[1:0], DIM_I};
		next_r.flt_sync = {r.flt_sync[1:0], FAULT_N_I};
		if (r.en_sync[1] == r.en_sync[2]) next_r.en_q = r.en_sync[2];
		if (r.dim_sync[1] == r.dim_sync[2]) next_r.dim_q = r.dim_sync[2];
		if (r.flt_sync[1] == r.flt_sync[2]) next_r.flt_q = r.flt_sync[2];
		next_r.dim_prev = r.dim_q;
		next_r.en_prev = r.en_q;

		// Sleep entry, and fault clearing on wake or long dimming-low.
		if (!r.en_q && en_low_long) begin
			next_r.phase = LFS_SLEEP;
		end
		if (r.phase == LFS_SLEEP && r.en_q && !r.en_prev) begin
			clear_all = 1'b1;
			next_r.phase = LFS_IDLE;
		end
		if (r.en_q && !r.dim_q && dim_low_long && r.phase != LFS_SLEEP) begin
			clear_all = 1'b1;
			next_r.phase = LFS_IDLE;
		end

		// Short detection only while some sink is regulating.
		armed = |SINK_IN_REG_I;
		if (armed && (r.phase == LFS_RUN || r.phase == LFS_SOFT_START)) begin
			short_hit = SINK_ABOVE_SHORT_I & ~r.ch_off;
		end
		ovp_startup = OVP_TRIP_I && r.phase == LFS_SOFT_START && (|(~SINK_IN_REG_I & ~r.ch_off));

		// External fault: count switching cycles with the line held low by others.
		if (ALL_OFF_VARIANT && !r.flt_q && !r.fault_drive) begin
			if (SW_CYCLE_I && r.ext_cnt < 8'(EXT_FAULT_LIMIT)) next_r.ext_cnt = r.ext_cnt + 8'h01;
		end else begin
			next_r.ext_cnt = 8'h00;
		end
		ext_fault = r.ext_cnt >= 8'(EXT_FAULT_LIMIT);

		// Latched fault records; a new event in the clearing cycle still lands.
		if (clear_all) begin
			next_r.ch_off = '0;
			next_r.global_off = 1'b0;
			next_r.fault_latch = 1'b0;
			next_r.ovp_hold = 1'b0;
		end
		if (|short_hit) begin
			next_r.fault_latch = 1'b1;
			if (ALL_OFF_VARIANT) begin
				next_r.global_off = 1'b1;
			end else begin
				next_r.ch_off = next_r.ch_off | short_hit;
			end
		end
		if (ovp_startup) begin
			next_r.fault_latch = 1'b1;
			if (ALL_OFF_VARIANT) begin
				next_r.global_off = 1'b1;
			end else begin
				next_r.ch_off = next_r.ch_off | ~SINK_IN_REG_I;
			end
		end
		if (ext_fault) begin
			next_r.global_off = 1'b1;
		end

		// Overvoltage stops switching until release, without a fault report.
		if (OVP_TRIP_I) begin
			next_r.ovp_hold = 1'b1;
		end else if (OVP_RELEASE_I) begin
			next_r.ovp_hold = 1'b0;
		end

		// Phase sequencing: soft start on each dimming rise from idle.
		case (next_r.phase)
			LFS_IDLE: begin
				if (r.dim_q && !r.dim_prev) next_r.phase = LFS_SOFT_START;
			end
			LFS_SOFT_START: begin
				if (SOFT_START_DONE_I) next_r.phase = LFS_RUN;
			end
			default: begin
			end
		endcase
		if (next_r.global_off && next_r.phase != LFS_SLEEP) next_r.phase = LFS_LATCHED_OFF;

		// Outputs registered from the next state.
		next_r.ctrl.sleep = next_r.phase == LFS_SLEEP;
		next_r.ctrl.bias_en = r.en_q || next_r.phase != LFS_SLEEP;
		next_r.ctrl.sync_clk_en = next_r.ctrl.bias_en;
		next_r.ctrl.soft_start = next_r.phase == LFS_SOFT_START;
		if ((next_r.phase == LFS_RUN || next_r.phase == LFS_SOFT_START) && r.dim_q) begin
			next_r.ctrl.sink_en = ~next_r.ch_off;
			next_r.ctrl.boost_en = !next_r.ovp_hold && (|next_r.ctrl.sink_en);
		end else begin
			next_r.ctrl.sink_en = '0;
			next_r.ctrl.boost_en = 1'b0;
		end
		next_r.fault_drive = next_r.fault_latch;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	// The fault chain resets high, the idle level of the pulled-up line, so no false low is seen.
	// Enable and dimming chains reset low, their idle levels.
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			r <= '0;
			r.en_sync <= 3'h0;
			r.dim_sync <= 3'h0;
			r.flt_sync <= 3'h7;
			r.flt_q <= 1'b1;
			r.phase <= LFS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Open drain: output value is always low, enable drives it.
	assign FAULT_N_O = 1'b0;
	assign FAULT_N_OE_O = r.fault_drive;
	assign SINK_EN_O = r.ctrl.sink_en;
	assign BOOST_EN_O = r.ctrl.boost_en;
	assign BIAS_EN_O = r.ctrl.bias_en;
	assign SYNC_CLK_EN_O = r.ctrl.sync_clk_en;
	assign SOFT_START_O = r.ctrl.soft_start;
	assign SLEEP_O = r.ctrl.sleep;
	assign CH_LATCHED_OFF_O = r.ch_off;
	assign GLOBAL_LATCHED_OFF_O = r.global_off;

endmodule : lfs_supervisor

// file: lfs_pkg.sv
package lfs_pkg;

	// Clock rate and documented timings.
	localparam int CLK_HZ = 200_000_000;
	localparam int ENABLE_OFF_DELAY_MS = 16;
	localparam int DIM_CLEAR_DELAY_MS = 16;
	localparam int ENABLE_OFF_CYCLES = CLK_HZ / 1000 * ENABLE_OFF_DELAY_MS;
	localparam int DIM_CLEAR_CYCLES = CLK_HZ / 1000 * DIM_CLEAR_DELAY_MS;
	localparam int EXT_FAULT_SW_CYCLES = 8;

	// Channel count and counter width.
	localparam int NUM_CH = 4;
	localparam int TMR_W = 24;

	// Operating phases of the converter.
	typedef enum logic [2:0] {
		LFS_SLEEP,
		LFS_IDLE,
		LFS_SOFT_START,
		LFS_RUN,
		LFS_LATCHED_OFF
	} lfs_phase_e;

	// Analog comparator flags presented to the supervisor.
	typedef struct packed {
		logic [NUM_CH-1:0] above_short;
		logic [NUM_CH-1:0] in_reg;
		logic ovp_trip;
		logic ovp_release;
	} lfs_sense_s;

	// Control outputs toward the power stage.
	typedef struct packed {
		logic [NUM_CH-1:0] sink_en;
		logic boost_en;
		logic bias_en;
		logic sync_clk_en;
		logic soft_start;
		logic sleep;
	} lfs_ctrl_s;

endpackage : lfs_pkg

// file: lfs_low_timer.sv
`timescale 1ns/1ps
// Counts how long an input level stays low; fires once past the limit.
module lfs_low_timer import lfs_pkg::*; #(
	parameter int LIMIT = DIM_CLEAR_CYCLES,
	parameter int W = TMR_W
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Level under watch and the expiry flag.
	input wire logic level_i,
	output logic expired_o
);

	// Refuse a limit that the counter cannot reach.
	if (LIMIT < 1 || LIMIT >= (1 << W)) begin : g_bad_limit
		$error("lfs_low_timer: LIMIT does not fit W");
	end

	typedef struct packed {
		logic [W-1:0] count;
		logic expired;
	} lfs_tmr_s;

	lfs_tmr_s r;
	lfs_tmr_s next_r;

	// Restart on every high; saturate once the limit is passed.
	always_comb begin
		next_r = r;
		if (level_i) begin
			next_r.count = '0;
			next_r.expired = 1'b0;
		end else if (r.count < W'(LIMIT)) begin
			next_r.count = r.count + W'(1);
		end else begin
			next_r.expired = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign expired_o = r.expired;

endmodule : lfs_low_timer

// file: lfs_supervisor_asserts.sv
`timescale 1ns/1ps
// Pin-level checks on the fault supervisor.
module lfs_supervisor_asserts import lfs_pkg::*; #(
	parameter int ENABLE_OFF_LIMIT = ENABLE_OFF_CYCLES
) (
	// Clock, reset and inputs.
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic ENABLE_I,
	input wire logic DIM_I,
	input wire logic OVP_TRIP_I,
	input wire logic SOFT_START_DONE_I,
	// Outputs.
	input wire logic FAULT_N_O,
	input wire logic FAULT_N_OE_O,
	input wire logic [NUM_CH-1:0] SINK_EN_O,
	input wire logic BOOST_EN_O,
	input wire logic BIAS_EN_O,
	input wire logic SYNC_CLK_EN_O,
	input wire logic SOFT_START_O,
	input wire logic SLEEP_O,
	input wire logic [NUM_CH-1:0] CH_LATCHED_OFF_O
);
	int low_cnt;
	// Raw enable-low run length; the pin filter only makes the device later.
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			low_cnt <= 0;
		else
			low_cnt <= ENABLE_I ? 0 : low_cnt + 1;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	fault_pin_low_a:
		assert property (FAULT_N_O == 1'b0) else $error("fault pin drives high");
	bias_kept_on_a:
		assert property (ENABLE_I [*8] |-> BIAS_EN_O && SYNC_CLK_EN_O)
		else $error("bias or sync off with enable high");
	ovp_stops_boost_a:
		assert property (OVP_TRIP_I [*3] |-> !BOOST_EN_O) else $error("boost runs on trip");
	short_channel_off_a:
		assert property (|CH_LATCHED_OFF_O |=> (SINK_EN_O & $past(CH_LATCHED_OFF_O)) == 4'h0)
		else $error("latched channel still sinks");
	short_fault_out_a:
		assert property ((|CH_LATCHED_OFF_O) [*2] |-> FAULT_N_OE_O)
		else $error("fault line released with latch");
	latch_clear_cause_a:
		assert property ($fell(|CH_LATCHED_OFF_O) |-> !DIM_I || $past(SLEEP_O, 2))
		else $error("latch cleared without cause");
	sleep_delay_a:
		assert property ($rose(SLEEP_O) |-> low_cnt > ENABLE_OFF_LIMIT)
		else $error("sleep entered too early");
	soft_start_end_a:
		assert property (SOFT_START_O && SOFT_START_DONE_I |=> !SOFT_START_O)
		else $error("soft start not ended");
	cover property ($rose(SLEEP_O));
	cover property ($rose(|CH_LATCHED_OFF_O));
	cover property ($fell(BOOST_EN_O));
endmodule : lfs_supervisor_asserts

// file: lfs_fault_line_model.sv
`timescale 1ns/1ps
// Host side: pulled-up wired-AND fault line, a peer driver and the switching tick.
module lfs_fault_line_model (
	input wire logic clk_i,
	input wire logic dev_oe_i,
	input wire logic peer_pull_i,
	output logic line_n_o,
	output logic sw_tick_o
);
	logic [1:0] div = 2'h0;
	// Released by everyone the pull-up wins, so the line reads high.
	assign line_n_o = !(dev_oe_i || peer_pull_i);
	// A tick every fourth clock keeps the peer-fault count short.
	always @(posedge clk_i) div <= div + 2'h1;
	assign sw_tick_o = (div == 2'h3);
endmodule : lfs_fault_line_model

// file: lfs_supervisor_bench.sv
`timescale 1ns/1ps
module lfs_supervisor_bench import lfs_pkg::*;;
	localparam int LIM = 50;
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, dim = 1'b0, trip = 1'b0, rel = 1'b0;
	logic done = 1'b0, peer = 1'b0, fn, oe, boost, bias, syn, ss, slp, glat, line_n, tick;
	logic [3:0] above = 4'h0, inreg = 4'h0, sink, lat;
	logic oe2, boost2, glat2, line2_n, tick2;
	logic [3:0] sink2;
	int bad_count = 0, n_checks = 0;
	always #2.5 clk = ~clk;
	lfs_fault_line_model model_u (.clk_i(clk), .dev_oe_i(oe), .peer_pull_i(peer),
		.line_n_o(line_n), .sw_tick_o(tick));
	lfs_supervisor #(.ENABLE_OFF_LIMIT(LIM), .DIM_CLEAR_LIMIT(LIM)) dut_u (.CLK_I(clk),
		.ARST_N_I(rst_n), .ENABLE_I(en), .DIM_I(dim), .SINK_ABOVE_SHORT_I(above),
		.SINK_IN_REG_I(inreg), .OVP_TRIP_I(trip), .OVP_RELEASE_I(rel), .SOFT_START_DONE_I(done),
		.SW_CYCLE_I(tick), .FAULT_N_I(line_n), .FAULT_N_O(fn), .FAULT_N_OE_O(oe),
		.SINK_EN_O(sink), .BOOST_EN_O(boost), .BIAS_EN_O(bias), .SYNC_CLK_EN_O(syn),
		.SOFT_START_O(ss), .SLEEP_O(slp), .CH_LATCHED_OFF_O(lat), .GLOBAL_LATCHED_OFF_O(glat));
	// Second device in the all-channels-off variant, on its own line with the same peer.
	if (1) begin : g_all_off
		lfs_fault_line_model model_u (.clk_i(clk), .dev_oe_i(oe2), .peer_pull_i(peer),
			.line_n_o(line2_n), .sw_tick_o(tick2));
		lfs_supervisor #(.ENABLE_OFF_LIMIT(LIM), .DIM_CLEAR_LIMIT(LIM),
			.ALL_OFF_VARIANT(1'b1)) dut_u (.CLK_I(clk),
			.ARST_N_I(rst_n), .ENABLE_I(en), .DIM_I(dim), .SINK_ABOVE_SHORT_I(above),
			.SINK_IN_REG_I(inreg), .OVP_TRIP_I(trip), .OVP_RELEASE_I(rel),
			.SOFT_START_DONE_I(done), .SW_CYCLE_I(tick2), .FAULT_N_I(line2_n), .FAULT_N_O(),
			.FAULT_N_OE_O(oe2), .SINK_EN_O(sink2), .BOOST_EN_O(boost2), .BIAS_EN_O(),
			.SYNC_CLK_EN_O(), .SOFT_START_O(), .SLEEP_O(), .CH_LATCHED_OFF_O(),
			.GLOBAL_LATCHED_OFF_O(glat2));
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// Raises dimming and waits, bounded, for soft start, then ends it.
	task automatic run_up;
		dim = 1'b1;
		for (int i = 0; i < 20 && ss !== 1'b1; i++) cyc(1);
		chk(4'(ss), 4'h1);
		if (ss !== 1'b1)
			report_and_stop();
		chk(4'(boost), 4'h1);
		done = 1'b1;
		cyc(1);
		done = 1'b0;
		cyc(2);
		chk(4'(ss), 4'h0);
		$display("run-up done");
	endtask : run_up
	// Shorts are ignored with no pin in regulation, then latch one channel.
	task automatic t_short;
		inreg = 4'h0;
		above = 4'h2;
		cyc(6);
		chk(lat, 4'h0);
		inreg = 4'hd;
		cyc(6);
		chk(sink, 4'hd);
		chk({lat[2:0], oe}, 4'h5);
		chk(sink2, 4'h0);
		chk({2'h0, glat2, oe2}, 4'h3);
		above = 4'h0;
		cyc(4);
		chk(lat, 4'h2);
		$display("short done");
	endtask : t_short
	// A broken dimming-low run keeps the latch; a long one clears it.
	task automatic t_dim_clear;
		dim = 1'b0;
		cyc(40);
		dim = 1'b1;
		cyc(10);
		dim = 1'b0;
		cyc(40);
		chk(lat, 4'h2);
		chk({2'h0, glat2, oe2}, 4'h3);
		cyc(20);
		chk({lat[2:0], oe}, 4'h0);
		chk({2'h0, glat2, oe2}, 4'h0);
		chk({slp, bias, syn}, 4'h3);
		inreg = 4'hf;
		run_up();
		$display("dim clear done");
	endtask : t_dim_clear
	// Overvoltage in run, then at start-up with channel 3 out of regulation.
	task automatic t_ovp(input logic [3:0] reg_mask, input logic [3:0] exp_lat);
		inreg = reg_mask;
		peer = 1'b1;
		trip = 1'b1;
		cyc(5);
		chk(4'(boost), 4'h0);
		chk({lat[2:0], oe}, {exp_lat[2:0], |exp_lat});
		chk(sink, ~exp_lat);
		chk({1'b0, boost2, glat2, oe2}, {2'h0, |exp_lat, |exp_lat});
		chk(sink2, (|exp_lat) ? 4'h0 : 4'hf);
		trip = 1'b0;
		peer = 1'b0;
		rel = 1'b1;
		cyc(5);
		rel = 1'b0;
		chk({boost, sink[2:0]}, 4'hf);
		chk({boost2, sink2[2:0]}, (|exp_lat) ? 4'h0 : 4'hf);
		$display("ovp done");
	endtask : t_ovp
	// Another driver holds the line low: only the all-off variant stops, after eight ticks.
	task automatic t_peer;
		peer = 1'b1;
		cyc(20);
		chk({1'b0, boost2, glat2, |sink2}, 4'h5);
		cyc(40);
		chk({1'b0, boost2, glat2, |sink2}, 4'h2);
		chk({1'b0, glat, boost, |sink}, 4'h3);
		peer = 1'b0;
		$display("peer fault done");
	endtask : t_peer
	// A short enable-low gap, then a real sleep and wake.
	task automatic t_sleep;
		dim = 1'b0;
		en = 1'b0;
		cyc(40);
		en = 1'b1;
		cyc(6);
		en = 1'b0;
		cyc(40);
		chk(4'(slp), 4'h0);
		cyc(30);
		chk(4'(slp), 4'h1);
		en = 1'b1;
		cyc(8);
		chk({slp, lat[3], oe}, 4'h0);
		chk({2'h0, glat2, oe2}, 4'h0);
		run_up();
		$display("sleep done");
	endtask : t_sleep
	// Reset for ten cycles, then each scenario in turn.
	initial begin
		cyc(10);
		rst_n = 1'b1;
		en = 1'b1;
		cyc(8);
		chk({bias, syn}, 4'h3);
		inreg = 4'hf;
		run_up();
		t_short();
		t_dim_clear();
		t_ovp(4'hf, 4'h0);
		t_peer();
		dim = 1'b0;
		cyc(60);
		inreg = 4'h7;
		dim = 1'b1;
		cyc(8);
		t_ovp(4'h7, 4'h8);
		t_sleep();
		report_and_stop();
	end
endmodule : lfs_supervisor_bench
bind lfs_supervisor lfs_supervisor_asserts #(.ENABLE_OFF_LIMIT(ENABLE_OFF_LIMIT)) chk_u (
	.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ENABLE_I(ENABLE_I), .DIM_I(DIM_I),
	.OVP_TRIP_I(OVP_TRIP_I), .SOFT_START_DONE_I(SOFT_START_DONE_I), .FAULT_N_O(FAULT_N_O),
	.FAULT_N_OE_O(FAULT_N_OE_O), .SINK_EN_O(SINK_EN_O), .BOOST_EN_O(BOOST_EN_O),
	.BIAS_EN_O(BIAS_EN_O), .SYNC_CLK_EN_O(SYNC_CLK_EN_O), .SOFT_START_O(SOFT_START_O),
	.SLEEP_O(SLEEP_O), .CH_LATCHED_OFF_O(CH_LATCHED_OFF_O));
